// ---- rtl/rdip_pkg.sv ----
package rdip_pkg;
    localparam int RDIP_NBITS = 54;
    localparam int RDIP_NBYTES = 7;
    localparam int RDIP_CLK_HZ = 20000000;
    // Time base: refclk / 12 / timebase
    localparam int RDIP_TB_REF_HZ = 11059200;
    localparam int RDIP_TB_DIV = 12;
    localparam logic [15:0] RDIP_TB_MIN = 16'h039a;
    localparam logic [15:0] RDIP_TB_DEFAULT = 16'h2400;
    localparam logic [7:0] RDIP_CNT_MAX = 8'hff;
    localparam logic [7:0] RDIP_ADDR_NONE = 8'h00;
    localparam logic [2:0] RDIP_BAUD_DEFAULT = 3'h3;
    localparam int RDIP_DATA_BITS = 7;
    localparam int RDIP_STOP_BITS = 1;
    localparam int RDIP_LOG_DEPTH = 256;
    localparam int RDIP_WDOG_CYCLES = 20000000;
    localparam logic [2:0] RDIP_BYTE_HI = 3'h6;
    localparam logic [5:0] RDIP_BIT_HI = 6'h35;
    // Baud codes 0..7: 1200,2400,4800,9600,14400,19200,28800,57600
    localparam logic [31:0] RDIP_BAUD_RATE [8] = '{32'd1200, 32'd2400,
        32'd4800, 32'd9600, 32'd14400, 32'd19200, 32'd28800, 32'd57600};

    typedef enum logic [3:0]
    {
        RDIP_OP_NONE = 4'h0,
        RDIP_OP_READ_BIT = 4'h1,
        RDIP_OP_READ_BYTE = 4'h2,
        RDIP_OP_READ_CNT = 4'h3,
        RDIP_OP_CLR_CNT = 4'h4,
        RDIP_OP_CLR_ALL = 4'h5,
        RDIP_OP_READ_FLAG = 4'h6,
        RDIP_OP_SET_MASK = 4'h7,
        RDIP_OP_SET_POL = 4'h8,
        RDIP_OP_READ_LOG = 4'h9
    } rdip_op_t;

    typedef struct packed
    {
        logic valid;
        rdip_op_t op;
        logic [5:0] index;
        logic [7:0] data;
    } rdip_req_t;

    typedef struct packed
    {
        logic valid;
        logic [7:0] data;
    } rdip_rsp_t;

    typedef struct packed
    {
        logic [7:0] podAddr;
        logic [2:0] baudCode;
        logic [15:0] timeBase;
    } rdip_nv_t;

    typedef enum logic [2:0]
    {
        RDIP_ST_IDLE = 3'b001,
        RDIP_ST_EXEC = 3'b010,
        RDIP_ST_RESP = 3'b100
    } rdip_state_t;
endpackage

// ---- rtl/rdip_tick_gen.sv ----
module rdip_tick_gen
    import rdip_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [15:0] timeBase,
    output logic tick
);
    // Reference ticks of timebase units scaled to our clock
    logic [31:0] acc_q;
    logic [31:0] acc_d;
    logic tick_q;
    logic tick_d;
    logic [31:0] limit;

    always_comb
    begin
        limit = 32'(timeBase) * 32'(RDIP_TB_DIV) * 32'd20;
        acc_d = acc_q + 32'd11;
        tick_d = 1'b0;
        // Fractional step keeps 11.0592/20 ratio close without a PLL
        if (acc_d >= limit)
        begin
            acc_d = 32'd0;
            tick_d = 1'b1;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            acc_q <= 32'd0;
            tick_q <= 1'b0;
        end
        else
        begin
            acc_q <= acc_d;
            tick_q <= tick_d;
        end
    end

    assign tick = tick_q;
endmodule

// ---- rtl/remote_digital_input_pod.sv ----
// Operation
// R1 - Fifty-four input lines sampled, each a numbered bit.
// R2 - Half-duplex link; pod drives only while answering.
// R3 - Host may share the link with up to thirty-one nodes.
// R4 - Pod address stored non-volatile, reloaded at power-on.
// R5 - Baud code stored non-volatile, applied after power-on.
// R6 - Programmable time base paces sampling, 14 Hz to 1 kHz.
// R7 - Inputs answered as single bit or eight-bit byte.
// R8 - Per-input counter counts selected edge only, up to 255.
// R9 - Counters readable and clearable by host.
// R10 - Change on enabled input sets the change flag, host reads it.
// R11 - Per-bit enable mask; masked bits never set the flag.
// R12 - Watchdog resets the pod when not serviced.
// R13 - Samples logged to local memory for later read-back.
// R14 - Characters use seven data bits, even parity, one stop.
// R15 - Nonzero address means addressed mode, zero non-addressed.
// R16 - Reading the change flag returns it and clears it.
// R17 - Host waits for each answer before the next command.
// R18 - Counter at 255 holds until cleared.
// R19 - Each tick compares inputs with previous sample.
module remote_digital_input_pod
    import rdip_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [RDIP_NBITS-1:0] dataIn,
    input wire rdip_req_t req,
    input wire rdip_nv_t nvStored,
    input wire logic nvWrite,
    input wire rdip_nv_t nvWriteData,
    input wire logic wdogKick,
    output rdip_rsp_t rsp,
    output logic reqReady,
    output logic txEnable,
    output rdip_nv_t nvActive,
    output rdip_nv_t nvImage,
    output logic addressedMode,
    output logic [31:0] baudRate,
    output logic change_detect_flag,
    output logic wdogReset
);
    rdip_state_t state_q;
    rdip_state_t state_d;
    rdip_req_t cur_q;
    rdip_req_t cur_d;
    rdip_rsp_t rsp_q;
    rdip_rsp_t rsp_d;
    rdip_nv_t active_q;
    rdip_nv_t active_d;
    rdip_nv_t image_q;
    rdip_nv_t image_d;
    logic loaded_q;
    logic loaded_d;
    logic [RDIP_NBITS-1:0] samp_q;
    logic [RDIP_NBITS-1:0] samp_d;
    logic [RDIP_NBITS-1:0] mask_q;
    logic [RDIP_NBITS-1:0] mask_d;
    logic [RDIP_NBITS-1:0] pol_q;
    logic [RDIP_NBITS-1:0] pol_d;
    logic [7:0] cnt_q [RDIP_NBITS];
    logic [7:0] cnt_d [RDIP_NBITS];
    logic flag_q;
    logic flag_d;
    logic [7:0] logMem [RDIP_LOG_DEPTH];
    logic [7:0] logWr_q;
    logic [7:0] logWr_d;
    logic [7:0] logRd_q;
    logic [7:0] logRd_d;
    logic [2:0] logLane_q;
    logic [2:0] logLane_d;
    logic [24:0] wdog_q;
    logic [24:0] wdog_d;
    logic wdogFire_q;
    logic wdogFire_d;
    logic tick;
    logic podReset;
    logic [15:0] tbSel;

    function automatic logic [7:0] byteOf(logic [RDIP_NBITS-1:0] v,
        logic [2:0] p);
        return 8'(64'(v) >> (p * 8));
    endfunction

    function automatic logic [RDIP_NBITS-1:0] setByte(
        logic [RDIP_NBITS-1:0] v, logic [2:0] p, logic [7:0] b);
        logic [63:0] w;
        w = 64'(v);
        w[p*8 +: 8] = b;
        return w[RDIP_NBITS-1:0];
    endfunction

    function automatic logic [15:0] tbValid(logic [15:0] t);
        return (t < RDIP_TB_MIN) ? RDIP_TB_DEFAULT : t;
    endfunction

    // Watchdog reset folds into the pod reset
    assign podReset = reset | wdogFire_q; // R12
    assign tbSel = tbValid(active_q.timeBase); // R6

    rdip_tick_gen u_tick
    (
        .clk_sys(clk_sys),
        .reset(podReset),
        .timeBase(tbSel),
        .tick(tick)
    );

    // Watchdog
    always_comb
    begin
        wdog_d = wdog_q + 25'd1;
        wdogFire_d = 1'b0;
        if (wdogKick)
            wdog_d = 25'd0;
        else if (wdog_q == 25'(RDIP_WDOG_CYCLES - 1)) // R12
        begin
            wdog_d = 25'd0;
            wdogFire_d = 1'b1;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            wdog_q <= 25'd0;
            wdogFire_q <= 1'b0;
        end
        else
        begin
            wdog_q <= wdog_d;
            wdogFire_q <= wdogFire_d;
        end
    end

    // Non-volatile image: writes reach active settings only at next load
    always_comb
    begin
        active_d = active_q;
        image_d = image_q;
        loaded_d = 1'b1;
        if (!loaded_q)
        begin
            active_d = nvStored; // R4 R5
            image_d = nvStored;
        end
        if (nvWrite)
            image_d = nvWriteData; // R4 R5
    end

    always_ff @(posedge clk_sys)
    begin
        if (podReset)
        begin
            active_q <= '{RDIP_ADDR_NONE, RDIP_BAUD_DEFAULT, RDIP_TB_DEFAULT};
            image_q <= '{RDIP_ADDR_NONE, RDIP_BAUD_DEFAULT, RDIP_TB_DEFAULT};
            loaded_q <= 1'b0;
        end
        else
        begin
            active_q <= active_d;
            image_q <= image_d;
            loaded_q <= loaded_d;
        end
    end

    // Sampling, counters, flag
    always_comb
    begin
        samp_d = samp_q;
        mask_d = mask_q;
        pol_d = pol_q;
        cnt_d = cnt_q;
        flag_d = flag_q;
        // First sample after reset taken as is, so no false edges
        if (tick || !loaded_q)
            samp_d = dataIn; // R1
        if (state_q == RDIP_ST_EXEC)
            unique case (cur_q.op)
                RDIP_OP_SET_MASK: // R11
                    mask_d = setByte(mask_q, cur_q.index[2:0], cur_q.data);
                RDIP_OP_SET_POL:
                    pol_d[cur_q.index] = cur_q.data[0]; // R8
                RDIP_OP_CLR_CNT:
                    cnt_d[cur_q.index] = 8'h00; // R9
                RDIP_OP_CLR_ALL:
                    cnt_d = '{default: 8'h00}; // R9
                RDIP_OP_READ_FLAG:
                    flag_d = 1'b0; // R16
                default: ;
            endcase
        // Edge evaluation after clears so a fresh event wins
        for (int i = 0; i < RDIP_NBITS; i++)
            if (dataIn[i] != samp_q[i] && tick) // R19
            begin
                if (mask_q[i])
                    flag_d = 1'b1; // R10 R11
                if (dataIn[i] == pol_q[i] && cnt_d[i] != RDIP_CNT_MAX)
                    cnt_d[i] = cnt_d[i] + 8'h01; // R8 R18
            end
    end

    always_ff @(posedge clk_sys)
    begin
        if (podReset)
        begin
            samp_q <= '0;
            mask_q <= '0;
            pol_q <= '1;
            cnt_q <= '{default: 8'h00};
            flag_q <= 1'b0;
        end
        else
        begin
            samp_q <= samp_d;
            mask_q <= mask_d;
            pol_q <= pol_d;
            cnt_q <= cnt_d;
            flag_q <= flag_d;
        end
    end

    // Logging: one sample byte lane per tick, oldest overwritten
    always_comb
    begin
        logWr_d = logWr_q;
        logLane_d = logLane_q;
        logRd_d = logRd_q;
        if (tick)
        begin
            logWr_d = logWr_q + 8'h01; // R13
            logLane_d = (logLane_q == RDIP_BYTE_HI) ? 3'h0 : logLane_q + 3'h1;
        end
        if (state_q == RDIP_ST_EXEC && cur_q.op == RDIP_OP_READ_LOG)
            logRd_d = logRd_q + 8'h01;
    end

    always_ff @(posedge clk_sys)
    begin
        if (tick)
            logMem[logWr_q] <= byteOf(dataIn, logLane_q); // R13
        if (podReset)
        begin
            logWr_q <= 8'h00;
            logLane_q <= 3'h0;
            logRd_q <= 8'h00;
        end
        else
        begin
            logWr_q <= logWr_d;
            logLane_q <= logLane_d;
            logRd_q <= logRd_d;
        end
    end

    // Command engine; one command in flight at a time
    always_comb
    begin
        state_d = state_q;
        cur_d = cur_q;
        rsp_d = '0;
        unique case (state_q)
            RDIP_ST_IDLE:
                if (req.valid) // R17
                begin
                    cur_d = req;
                    state_d = RDIP_ST_EXEC;
                end
            RDIP_ST_EXEC:
            begin
                rsp_d.valid = 1'b1;
                unique case (cur_q.op)
                    RDIP_OP_READ_BIT:
                        rsp_d.data = {7'h00, samp_q[cur_q.index]}; // R7
                    RDIP_OP_READ_BYTE:
                        rsp_d.data = byteOf(samp_q, cur_q.index[2:0]); // R7
                    RDIP_OP_READ_CNT:
                        rsp_d.data = cnt_q[cur_q.index]; // R9
                    RDIP_OP_READ_FLAG:
                        rsp_d.data = {7'h00, flag_q}; // R16
                    RDIP_OP_READ_LOG:
                        rsp_d.data = logMem[logRd_q]; // R13
                    default:
                        rsp_d.data = 8'h00;
                endcase
                state_d = RDIP_ST_RESP;
            end
            RDIP_ST_RESP:
                state_d = RDIP_ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (podReset)
        begin
            state_q <= RDIP_ST_IDLE;
            cur_q <= '0;
            rsp_q <= '0;
        end
        else
        begin
            state_q <= state_d;
            cur_q <= cur_d;
            rsp_q <= rsp_d;
        end
    end

    // Registered outputs
    logic ready_q;
    logic mode_q;
    logic [31:0] baud_q;
    always_ff @(posedge clk_sys)
    begin
        if (podReset)
        begin
            ready_q <= 1'b0;
            mode_q <= 1'b0;
            baud_q <= 32'd9600;
        end
        else
        begin
            ready_q <= (state_d == RDIP_ST_IDLE);
            mode_q <= (active_d.podAddr != RDIP_ADDR_NONE); // R15
            baud_q <= RDIP_BAUD_RATE[active_d.baudCode]; // R5
        end
    end

    assign rsp = rsp_q;
    assign reqReady = ready_q;
    assign txEnable = rsp_q.valid; // R2
    assign nvActive = active_q;
    assign nvImage = image_q;
    assign addressedMode = mode_q;
    assign baudRate = baud_q;
    assign change_detect_flag = flag_q;
    assign wdogReset = wdogFire_q;
endmodule

// ---- verification/rdip_pod_chk.sv ----
module rdip_pod_chk
    import rdip_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire rdip_req_t req,
    input wire logic nvWrite,
    input wire rdip_nv_t nvWriteData,
    input wire rdip_rsp_t rsp,
    input wire logic reqReady,
    input wire logic txEnable,
    input wire rdip_nv_t nvActive,
    input wire rdip_nv_t nvImage,
    input wire logic addressedMode,
    input wire logic [31:0] baudRate,
    input wire logic change_detect_flag,
    input wire logic wdogReset
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);
    wire taken = req.valid && reqReady;
    wire flagRd = taken && req.op == RDIP_OP_READ_FLAG;
    property p_answer;
        taken |-> ##2 rsp.valid;
    endproperty
    a_answer: assert property (p_answer) else $error("late answer");
    property p_drive;
        txEnable == rsp.valid;
    endproperty
    a_drive: assert property (p_drive) else $error("drive off");
    property p_pulse;
        rsp.valid |=> !rsp.valid && !txEnable;
    endproperty
    a_pulse: assert property (p_pulse) else $error("long answer");
    property p_busy;
        rsp.valid |-> !reqReady ##1 reqReady;
    endproperty
    a_busy: assert property (p_busy) else $error("ready wrong");
    // Settings judged only once they have sat a cycle
    property p_mode;
        !$past(reset) && $stable(nvActive) |->
            addressedMode == (nvActive.podAddr != RDIP_ADDR_NONE);
    endproperty
    a_mode: assert property (p_mode) else $error("mode wrong");
    property p_baud;
        !$past(reset) && $stable(nvActive) |->
            baudRate == RDIP_BAUD_RATE[nvActive.baudCode];
    endproperty
    a_baud: assert property (p_baud) else $error("baud wrong");
    property p_clear;
        flagRd |-> ##2 !change_detect_flag;
    endproperty
    a_clear: assert property (p_clear) else $error("flag kept");
    property p_report;
        flagRd && change_detect_flag |-> ##2 rsp.data[0];
    endproperty
    a_report: assert property (p_report) else $error("flag lost");
    property p_image;
        nvWrite |=> nvImage == $past(nvWriteData) && $stable(nvActive);
    endproperty
    a_image: assert property (p_image) else $error("image wrong");
    property p_wdog;
        wdogReset |=> !wdogReset;
    endproperty
    a_wdog: assert property (p_wdog) else $error("long reset");
    c_flag: cover property (flagRd && change_detect_flag);
    c_mode: cover property (addressedMode);
    c_write: cover property (nvWrite);
endmodule

// ---- verification/rdip_host.sv ----
module rdip_host
    import rdip_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reqReady,
    input wire rdip_rsp_t rsp,
    output rdip_req_t req
);
    timeunit 1ns;
    timeprecision 1ns;
    initial req = '0;
    // Sole host on the link; one command in flight at a time
    task automatic xfer(input rdip_op_t op, input logic [5:0] idx,
        input logic [7:0] dat, output logic [7:0] rd, output bit ok);
        int n;
        n = 0;
        @(posedge clk_sys);
        #2;
        while (reqReady !== 1'h1 && n < 50)
        begin
            @(posedge clk_sys);
            #2 n++;
        end
        req = '{1'h1, op, idx, dat};
        @(posedge clk_sys);
        // Idle fields scrambled so stale values never look valid
        #2 req = '{1'h0, rdip_op_t'(~op), ~idx, ~dat};
        while (rsp.valid !== 1'h1 && n < 50)
        begin
            @(posedge clk_sys);
            #2 n++;
        end
        rd = rsp.data;
        ok = n < 50;
    endtask
endmodule

// ---- verification/remote_digital_input_pod_tb.sv ----
module remote_digital_input_pod_tb
    import rdip_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys, reset, nvWrite, wdogKick, txEnable, addressedMode;
    logic reqReady, change_detect_flag, wdogReset;
    logic [53:0] dataIn, prev, mask, pol;
    logic [31:0] baudRate;
    rdip_req_t req;
    rdip_rsp_t rsp;
    rdip_nv_t nvStored, nvWriteData, nvActive, nvImage;
    int cnt[54];
    int rate[8] = '{1200, 2400, 4800, 9600, 14400, 19200, 28800, 57600};
    int bad_count = 0;
    int check_count = 0;
    int cyc = 0;
    bit flg;
    remote_digital_input_pod u_dut (.clk_sys(clk_sys), .reset(reset),
        .dataIn(dataIn), .req(req), .nvStored(nvStored), .nvWrite(nvWrite),
        .nvWriteData(nvWriteData), .wdogKick(wdogKick), .rsp(rsp),
        .reqReady(reqReady), .txEnable(txEnable), .nvActive(nvActive),
        .nvImage(nvImage), .addressedMode(addressedMode),
        .baudRate(baudRate), .change_detect_flag(change_detect_flag),
        .wdogReset(wdogReset));
    rdip_host u_host (.clk_sys(clk_sys), .reqReady(reqReady), .rsp(rsp),
        .req(req));
    always #25 clk_sys = ~clk_sys;
    always @(posedge clk_sys)
    begin
        #2 wdogKick = ($urandom_range(999) == 0);
        cyc++;
        if (cyc > 99000)
        begin
            bad_count++;
            results();
        end
    end
    task automatic results();
        $display("Checks %0d errors %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("ERROR %0t got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic cmd(input rdip_op_t op, input logic [5:0] i,
        input logic [7:0] d, output logic [7:0] r);
        bit ok;
        u_host.xfer(op, i, d, r, ok);
        if (!ok)
        begin
            bad_count++;
            $display("ERROR %0t no answer", $time);
        end
    endtask
    // Long wait covers one full tick at the fastest time base
    task automatic settle(input logic [53:0] v);
        @(posedge clk_sys);
        #2 dataIn = v;
        repeat (21000) @(posedge clk_sys);
        for (int i = 0; i < 54; i++)
            if (v[i] != prev[i] && v[i] == pol[i] && cnt[i] < 255)
                cnt[i]++;
        if (((v ^ prev) & mask) != 0)
            flg = 1;
        prev = v;
    endtask
    task automatic rflag();
        logic [7:0] r;
        cmd(RDIP_OP_READ_FLAG, 6'h00, 8'h00, r);
        chk(r, 8'(flg));
        flg = 0;
    endtask
    task automatic checkall();
        logic [7:0] r;
        for (int p = 0; p < 7; p++)
        begin
            cmd(RDIP_OP_READ_BYTE, 6'(p), 8'h00, r);
            chk(r, 8'(prev >> (p * 8)));
        end
        for (int i = 0; i < 54; i++)
        begin
            cmd(RDIP_OP_READ_BIT, 6'(i), 8'h00, r);
            chk(r, 8'(prev[i]));
            cmd(RDIP_OP_READ_CNT, 6'(i), 8'h00, r);
            chk(r, 8'(cnt[i]));
        end
    endtask
    initial
    begin
        logic [53:0] v;
        logic [7:0] m, r;
        void'($urandom(28256));
        {clk_sys, nvWrite, wdogKick, reset} = 4'h1;
        nvWriteData = '0;
        dataIn = 54'({$urandom, $urandom});
        pol = '1;
        mask = '0;
        for (int c = 0; c < 8; c++)
        begin
            nvStored = '{c ? 8'($urandom_range(1, 255)) : 8'h00, 3'(c),
                16'h039a};
            reset = 1'h1;
            repeat (8) @(posedge clk_sys);
            #2 reset = 1'h0;
            repeat (3) @(posedge clk_sys);
            #2;
            chk(baudRate, rate[c]);
            chk(nvActive, nvStored);
            chk(addressedMode, c != 0);
        end
        nvWriteData = '{8'($urandom), 3'($urandom), 16'($urandom)};
        nvWrite = 1'h1;
        @(posedge clk_sys);
        #2 nvWrite = 1'h0;
        chk(nvImage, nvWriteData);
        chk(nvActive, nvStored);
        repeat (21000) @(posedge clk_sys);
        cmd(RDIP_OP_CLR_ALL, 6'h00, 8'h00, r);
        cmd(RDIP_OP_READ_FLAG, 6'h00, 8'h00, r);
        prev = dataIn;
        cmd(RDIP_OP_READ_LOG, 6'h00, 8'h00, r);
        chk(r, 8'(prev));
        cnt = '{default: 0};
        flg = 0;
        m = 8'($urandom_range(1, 255));
        for (int p = 0; p < 7; p++)
            cmd(RDIP_OP_SET_MASK, 6'(p), p == 1 ? m : 8'h00, r);
        mask = 54'(m) << 8;
        settle(prev ^ (54'({$urandom, $urandom}) & ~(54'hff << 8)));
        rflag();
        settle(prev ^ mask);
        rflag();
        rflag();
        checkall();
        cmd(RDIP_OP_CLR_CNT, 6'h03, 8'h00, r);
        cnt[3] = 0;
        for (int i = 0; i < 54; i += 2)
        begin
            cmd(RDIP_OP_SET_POL, 6'(i), 8'h00, r);
            pol[i] = 0;
        end
        settle(~prev);
        rflag();
        checkall();
        chk(32'(wdogReset), 32'h0);
        results();
    end
endmodule
bind remote_digital_input_pod rdip_pod_chk u_chk (.clk_sys(clk_sys),
    .reset(reset), .req(req), .nvWrite(nvWrite),
    .nvWriteData(nvWriteData), .rsp(rsp), .reqReady(reqReady),
    .txEnable(txEnable), .nvActive(nvActive), .nvImage(nvImage),
    .addressedMode(addressedMode), .baudRate(baudRate),
    .change_detect_flag(change_detect_flag), .wdogReset(wdogReset));
